// ==== pga_host_model.sv ====
// Host-side model: pin line with pull-up and reaction to power-good loss
`timescale 1ns/1ps
`default_nettype none
module pga_host_model (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  input  wire logic pol_i,
  input  wire logic ack_i,
  output logic      pg_seen_o,
  output logic      read_req_o
);
  logic line;
  logic seen_ff;
  // Released pin floats to the pull-up, never the last driven value
  assign line      = pin_oe_i ? pin_i : 1'b1;
  assign pg_seen_o = line ^ pol_i;
  always_ff @(posedge sys_clk_i) begin
    seen_ff <= pg_seen_o;
    if (rst_i || ack_i) read_req_o <= 1'b0;
    else if (seen_ff && !pg_seen_o) read_req_o <= 1'b1;
  end
endmodule
`default_nettype wire

// ==== pga_pkg.sv ====
// Package: constants, register map and state types of the power-good aggregator
package pga_pkg;

  // ==========================================================================
  // Sizes and timing
  localparam int PGA_NUM_RAILS = 4;             // Bit 0..1 switchers, bit 2..3 linear
  localparam int PGA_CLK_MHZ   = 125;
  localparam int PGA_GATE_US   = 800;
  localparam int PGA_GATE_CYC  = PGA_GATE_US * PGA_CLK_MHZ;
  localparam int PGA_TMR_W     = 17;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] PGA_OFS_CTRL1  = 8'h00;  // monitor_control_one
  localparam logic [7:0] PGA_OFS_CTRL2  = 8'h04;  // monitor_control_two
  localparam logic [7:0] PGA_OFS_FAULT  = 8'h08;  // latched_fault_register
  localparam logic [7:0] PGA_OFS_INT    = 8'h0c;  // input overvoltage / shutdown flags
  localparam logic [7:0] PGA_OFS_STAT   = 8'h10;  // live status, read only

  // ==========================================================================
  // Field positions
  localparam int PGA_C1_SEL_LSB = 0;   // [3:0] rail monitor selects
  localparam int PGA_C1_WIN_LSB = 4;   // [7:4] rail window check selects
  localparam int PGA_C1_POL     = 8;   // output_polarity_select
  localparam int PGA_C1_OD      = 9;   // open_drain_select
  localparam int PGA_C2_TWSEL   = 0;   // thermal_warning_monitor_select
  localparam int PGA_C2_MODE    = 1;   // gated_continuous_select
  localparam int PGA_C2_FHOLD   = 2;   // fault_holds_output_low
  localparam int PGA_F_TW       = 4;   // Thermal warning fault bit
  localparam int PGA_I_OVP      = 0;   // input_overvoltage_flag
  localparam int PGA_I_TSD      = 1;   // thermal_shutdown_flag
  localparam int PGA_S_PG       = 0;
  localparam int PGA_S_GATE     = 1;
  localparam int PGA_S_HALT     = 2;
  localparam int PGA_S_OK_LSB   = 4;

  localparam logic [1:0] PGA_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PGA_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {PGA_PH_PRELOAD, PGA_PH_RUN, PGA_PH_HALT} pga_phase_t;

  typedef struct packed {
    logic [PGA_NUM_RAILS-1:0] enable;    // Regulator internal enable
    logic [PGA_NUM_RAILS-1:0] uv_ok;     // Above undervoltage threshold
    logic [PGA_NUM_RAILS-1:0] ov_ok;     // Below overvoltage threshold
    logic [PGA_NUM_RAILS-1:0] ramping;   // Moving between two targets
    logic [PGA_NUM_RAILS-1:0] vchange;   // One-cycle voltage change request
  } pga_rail_t;

  typedef struct packed {
    pga_phase_t               phase;
    logic                     mode;
    logic [9:0]               ctrl1;
    logic [2:0]               ctrl2;
    logic [4:0]               fault;
    logic                     ovp_flag;
    logic                     tsd_flag;
    logic [PGA_NUM_RAILS-1:0] en_prev;
    logic [PGA_TMR_W-1:0]     gate_cnt;
    logic                     pg;
    logic                     pin_out;
    logic                     pin_oe;
    logic                     aw_full;
    logic [7:0]               awaddr;
    logic                     w_full;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
  } pga_state_t;

  localparam pga_state_t PGA_STATE_RST = '0;

endpackage

// ==== pga_power_good_aggregator.sv ====
// Power-good aggregator with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Per-rail select includes rail in aggregation
// - Disabled rails are masked automatically
// - Select bit adds thermal warning source
// - Power-good only when all sources valid
// - Window bit: 0 UV only, 1 UV+OV
// - Polarity and push-pull/open-drain select bits
// - Polarity inverts pin only, status fixed
// - Mode bit from OTP: 0 gated, 1 continuous
// - Gated: active after OTP load exit
// - Gated: hold state for 800 us
// - Gated: after gate, invalid drives inactive
// - Detected fault sets per-source fault bit
// - Gated: monitoring stops until fault cleared
// - Host clears flags and faults writing 1
// - Overvoltage clear ignored while still over
// - UVLO reset clears all faults and flags
// - Continuous: inactive when a selected rail enables
// - Continuous: output follows regulation live
// - Fault bits latched until written 1
// - Inactive while rail changes target voltage
// - Continuous default: recovers active despite latched faults
// - Fault gating bit holds inactive while pending
module pga_power_good_aggregator
  import pga_pkg::*;
#(
  parameter int GATE_CYCLES = PGA_GATE_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        otp_load_done_i,
  input  wire logic        otp_mode_i,
  input  wire pga_rail_t   rail_i,
  input  wire logic        thermal_warning_status_i,
  input  wire logic        input_overvoltage_i,
  input  wire logic        thermal_shutdown_i,
  output logic             power_good_output_o,
  output logic             power_good_output_oe_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);

  localparam logic [PGA_TMR_W-1:0] GATE_LOAD = PGA_TMR_W'(GATE_CYCLES);

  pga_state_t st_ff;
  pga_state_t nxt_st;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] pga_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic pga_mapped(input logic [7:0] addr);
    return (addr == PGA_OFS_CTRL1) || (addr == PGA_OFS_CTRL2) ||
           (addr == PGA_OFS_FAULT) || (addr == PGA_OFS_INT) ||
           (addr == PGA_OFS_STAT);
  endfunction

  // ==========================================================================
  // Source evaluation
  logic [PGA_NUM_RAILS-1:0] sel;
  logic [PGA_NUM_RAILS-1:0] win;
  logic [PGA_NUM_RAILS-1:0] in_reg;
  logic [PGA_NUM_RAILS-1:0] rail_bad;
  logic [PGA_NUM_RAILS-1:0] rail_flt;
  logic [PGA_NUM_RAILS-1:0] en_rise;
  logic                     tw_bad;
  logic                     src_bad;
  logic                     restart;
  logic                     gating;

  always_comb begin
    sel      = st_ff.ctrl1[PGA_C1_SEL_LSB +: PGA_NUM_RAILS];
    win      = st_ff.ctrl1[PGA_C1_WIN_LSB +: PGA_NUM_RAILS];
    in_reg   = rail_i.uv_ok & (~win | rail_i.ov_ok);
    rail_bad = sel & rail_i.enable & ~(in_reg & ~rail_i.ramping);
    // Ramps are expected excursions, so they do not latch a fault
    rail_flt = sel & rail_i.enable & ~in_reg & ~rail_i.ramping;
    en_rise  = rail_i.enable & ~st_ff.en_prev;
    tw_bad   = st_ff.ctrl2[PGA_C2_TWSEL] & thermal_warning_status_i;
    src_bad  = (|rail_bad) | tw_bad | st_ff.ovp_flag | st_ff.tsd_flag;
    restart  = (|en_rise) | (|(rail_i.vchange & rail_i.enable));
    gating   = (st_ff.gate_cnt != '0);
  end

  // ==========================================================================
  // Next state
  logic        wr_go;
  logic [31:0] wmask;
  logic        fault_pend;
  logic        hold_low;
  logic        mon_live;
  logic        pg_next;
  logic [31:0] rd_val;
  logic [31:0] c1_new;

  always_comb begin
    nxt_st     = st_ff;
    wr_go      = st_ff.aw_full && st_ff.w_full && !st_ff.bvalid;
    wmask      = '0;
    fault_pend = 1'b0;
    hold_low   = 1'b0;
    mon_live   = 1'b0;
    pg_next    = st_ff.pg;
    rd_val     = '0;
    c1_new     = pga_merge({22'h0, st_ff.ctrl1}, st_ff.wdata, st_ff.wstrb);

    nxt_st.en_prev = rail_i.enable;

    // Write-one-to-clear mask built from the low byte lane only
    if (wr_go && st_ff.wstrb[0]) begin
      wmask = {24'h0, st_ff.wdata[7:0]};
    end

    // Register writes
    if (wr_go) begin
      nxt_st.aw_full = 1'b0;
      nxt_st.w_full  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = pga_mapped(st_ff.awaddr) ? PGA_RESP_OKAY : PGA_RESP_SLVERR;
      case (st_ff.awaddr)
        PGA_OFS_CTRL1: begin
          nxt_st.ctrl1 = c1_new[9:0];
        end
        PGA_OFS_CTRL2: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.ctrl2 = st_ff.wdata[2:0];
            nxt_st.mode  = st_ff.wdata[PGA_C2_MODE];
          end
        end
        PGA_OFS_FAULT: begin
          nxt_st.fault = st_ff.fault & ~wmask[4:0];
        end
        PGA_OFS_INT: begin
          if (wmask[PGA_I_OVP] && !input_overvoltage_i) begin
            nxt_st.ovp_flag = 1'b0;
          end
          if (wmask[PGA_I_TSD] && !thermal_shutdown_i) begin
            nxt_st.tsd_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Hardware sets come after the clears so a same-cycle event wins
    if (input_overvoltage_i) begin
      nxt_st.ovp_flag = 1'b1;
    end
    if (thermal_shutdown_i) begin
      nxt_st.tsd_flag = 1'b1;
    end

    // Gate timer
    if (st_ff.mode == 1'b0 && st_ff.phase != PGA_PH_PRELOAD && restart) begin
      nxt_st.gate_cnt = GATE_LOAD;
    end else if (gating) begin
      nxt_st.gate_cnt = st_ff.gate_cnt - PGA_TMR_W'(1);
    end

    // Fault latching, gated mode only while monitoring is live
    mon_live = (st_ff.phase == PGA_PH_RUN) && (st_ff.mode || !gating);
    if (mon_live) begin
      nxt_st.fault = nxt_st.fault | {tw_bad, rail_flt};
    end

    fault_pend = (|st_ff.fault) || st_ff.ovp_flag || st_ff.tsd_flag;
    hold_low   = st_ff.ctrl2[PGA_C2_FHOLD] && (|st_ff.fault);

    // Power-good sequencing
    case (st_ff.phase)
      PGA_PH_PRELOAD: begin
        pg_next = 1'b0;
        if (otp_load_done_i) begin
          nxt_st.mode  = otp_mode_i;
          nxt_st.phase = PGA_PH_RUN;
          pg_next      = 1'b1;
        end
      end
      PGA_PH_RUN: begin
        if (st_ff.mode) begin
          // Live tracking; a default recovery ignores latched fault bits
          pg_next = !src_bad && !hold_low && !(|(en_rise & sel));
        end else if (gating || restart) begin
          pg_next = st_ff.pg;
        end else if (src_bad) begin
          pg_next      = 1'b0;
          nxt_st.phase = PGA_PH_HALT;
        end else begin
          pg_next = !hold_low;
        end
      end
      PGA_PH_HALT: begin
        // Stuck inactive until software clears every pending cause or sets continuous mode
        pg_next = 1'b0;
        if (!fault_pend || st_ff.mode) begin
          nxt_st.phase = PGA_PH_RUN;
        end
      end
      default: begin
        nxt_st.phase = PGA_PH_PRELOAD;
        pg_next      = 1'b0;
      end
    endcase
    nxt_st.pg = pg_next;

    // Pin: polarity and drive type act on the pin alone
    if (nxt_st.ctrl1[PGA_C1_OD]) begin
      nxt_st.pin_out = 1'b0;
      nxt_st.pin_oe  = ~(pg_next ^ nxt_st.ctrl1[PGA_C1_POL]);
    end else begin
      nxt_st.pin_out = pg_next ^ nxt_st.ctrl1[PGA_C1_POL];
      nxt_st.pin_oe  = 1'b1;
    end

    // Write channel capture, either order
    if (s_axi_awvalid_i && st_ff.awready) begin
      nxt_st.aw_full = 1'b1;
      nxt_st.awaddr  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_ff.wready) begin
      nxt_st.w_full = 1'b1;
      nxt_st.wdata  = s_axi_wdata_i;
      nxt_st.wstrb  = s_axi_wstrb_i;
    end
    if (st_ff.bvalid && s_axi_bready_i) begin
      nxt_st.bvalid = 1'b0;
    end
    nxt_st.awready = !nxt_st.aw_full && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_full && !nxt_st.bvalid;

    // Read channel; status reads are live values
    case (s_axi_araddr_i)
      PGA_OFS_CTRL1: rd_val = {22'h0, st_ff.ctrl1};
      PGA_OFS_CTRL2: rd_val = {29'h0, st_ff.ctrl2[PGA_C2_FHOLD], st_ff.mode,
                               st_ff.ctrl2[PGA_C2_TWSEL]};
      PGA_OFS_FAULT: rd_val = {27'h0, st_ff.fault};
      PGA_OFS_INT:   rd_val = {30'h0, st_ff.tsd_flag, st_ff.ovp_flag};
      PGA_OFS_STAT:  rd_val = {24'h0, in_reg, 1'b0, (st_ff.phase == PGA_PH_HALT),
                               gating, st_ff.pg};
      default:       rd_val = '0;
    endcase
    if (st_ff.rvalid && s_axi_rready_i) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_val;
      nxt_st.rresp  = pga_mapped(s_axi_araddr_i) ? PGA_RESP_OKAY : PGA_RESP_SLVERR;
    end
    nxt_st.arready = !nxt_st.rvalid;
  end

  // ==========================================================================
  // State register; supply lockout lands here as reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_ff <= PGA_STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign power_good_output_o    = st_ff.pin_out;
  assign power_good_output_oe_o = st_ff.pin_oe;
  assign s_axi_awready_o        = st_ff.awready;
  assign s_axi_wready_o         = st_ff.wready;
  assign s_axi_bvalid_o         = st_ff.bvalid;
  assign s_axi_bresp_o          = st_ff.bresp;
  assign s_axi_arready_o        = st_ff.arready;
  assign s_axi_rvalid_o         = st_ff.rvalid;
  assign s_axi_rdata_o          = st_ff.rdata;
  assign s_axi_rresp_o          = st_ff.rresp;

endmodule

`default_nettype wire

// ==== pga_power_good_aggregator_assertions.sv ====
// Checker: bus handshake and pin relations of the power-good aggregator
`timescale 1ns/1ps
`default_nettype none
module pga_chk (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        power_good_output_o,
  input wire logic        power_good_output_oe_o,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Reset check must run while reset is high, so it opts out
  property p_rst; disable iff (1'b0) rst_i |=> !power_good_output_oe_o && !s_axi_arready_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs not quiet in reset");
  property p_od; power_good_output_o |-> power_good_output_oe_o; endproperty
  a_od: assert property (p_od) else $error("pin high while not driven");
  property p_wr; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o; endproperty
  a_wr: assert property (p_wr) else $error("write response late");
  property p_aw; s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o; endproperty
  a_aw: assert property (p_aw) else $error("address ready while write held");
  property p_bdone; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o; endproperty
  a_bdone: assert property (p_bdone) else $error("write channel not reopened");
  property p_bblk; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
  a_bblk: assert property (p_bblk) else $error("write ready during response");
  property p_rd; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_rd: assert property (p_rd) else $error("read data late");
  property p_rdone; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o; endproperty
  a_rdone: assert property (p_rdone) else $error("read channel not reopened");
  property p_rblk; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_rblk: assert property (p_rblk) else $error("read ready during response");
  c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
  c_od: cover property (!power_good_output_oe_o);
  c_rd: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule
bind pga_power_good_aggregator pga_chk pga_chk_inst (.*);
`default_nettype wire

// ==== tb_power_good_aggregator.sv ====
// Testbench: random rails and settings, model-checked pin and registers
`timescale 1ns/1ps
`default_nettype none
module tb_power_good_aggregator;
  import pga_pkg::*;
  localparam int GC = 20;
  logic        sys_clk_i = 1'b0, rst_i = 1'b1, otp_load_done_i = 1'b0, otp_mode_i = 1'b0;
  pga_rail_t   rail_i = '0;
  logic        thermal_warning_status_i = 1'b0, input_overvoltage_i = 1'b0;
  logic        thermal_shutdown_i = 1'b0, power_good_output_o, power_good_output_oe_o;
  logic [7:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, rdat, r;
  logic [3:0]  s_axi_wstrb_i = '0, sel = '0, win = '0;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, host_ack = 1'b0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp, fl_m = '0;
  logic [4:0]  fault_m = '0;
  logic        pol = 1'b0, od = 1'b0, twsel = 1'b0, fhold = 1'b0, pg_seen, rd_req;
  int          fail_count = 0, tests_run = 0, cyc = 0, seed = 32'hc5a9;

  pga_power_good_aggregator #(.GATE_CYCLES(GC)) pga_power_good_aggregator_inst (.*);
  pga_host_model pga_host_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .pin_i(power_good_output_o), .pin_oe_i(power_good_output_oe_o), .pol_i(pol),
    .ack_i(host_ack), .pg_seen_o(pg_seen), .read_req_o(rd_req));

  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  // ==========================================================================
  // Model and helpers
  function automatic logic rok(input int i);
    return rail_i.uv_ok[i] && (!win[i] || rail_i.ov_ok[i]);
  endfunction
  function automatic logic exp_pg();
    logic ok;
    ok = !(|fl_m) && !(twsel && thermal_warning_status_i) && !(fhold && |fault_m);
    for (int i = 0; i < 4; i++)
      if (sel[i] && rail_i.enable[i]) ok &= rok(i) && !rail_i.ramping[i];
    return ok;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st = 4'hf);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= st;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    resp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    rdat = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic boot(input logic m);
    @(posedge sys_clk_i);
    otp_mode_i <= m;
    otp_load_done_i <= 1'b1;
    @(posedge sys_clk_i);
    otp_load_done_i <= 1'b0;
  endtask
  task automatic settle(input string nm);
    repeat (3) @(posedge sys_clk_i);
    for (int i = 0; i < 4; i++)
      if (sel[i] && rail_i.enable[i] && !rail_i.ramping[i] && !rok(i)) fault_m[i] = 1'b1;
    if (twsel && thermal_warning_status_i) fault_m[4] = 1'b1;
    fl_m |= {thermal_shutdown_i, input_overvoltage_i};
    chk(nm, pg_seen, exp_pg());
    rd(PGA_OFS_STAT);
    chk("status", rdat[PGA_S_PG], exp_pg());
    rd(PGA_OFS_FAULT);
    chk("fault", rdat[4:0], fault_m);
    host_ack <= rd_req;
    rd(PGA_OFS_INT);
    host_ack <= 1'b0;
    chk("flags", rdat[1:0], fl_m);
    $display("test %s done", nm);
  endtask
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    boot(1'b0);
    settle("boot");
    rd(PGA_OFS_CTRL2);
    chk("mode", rdat[1], 1'b0);
    wr(PGA_OFS_CTRL1, 32'h1);
    sel = 4'h1;
    for (int k = 0; k < 2; k++) begin
      if (k == 0) rail_i.enable[0] <= 1'b1;
      else rail_i.vchange[0] <= 1'b1;
      rail_i.uv_ok[0] <= 1'b0;
      @(posedge sys_clk_i);
      rail_i.vchange[0] <= 1'b0;
      repeat (GC - 4) @(posedge sys_clk_i);
      chk("gate hold", pg_seen, 1'b1);
      repeat (8) @(posedge sys_clk_i);
      chk("gate end", pg_seen, 1'b0);
      rail_i.uv_ok[0] <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      chk("halted", pg_seen, 1'b0);
      rd(PGA_OFS_FAULT);
      chk("gate fault", rdat[0], 1'b1);
      wr(PGA_OFS_FAULT, 32'h1);
      settle("gated");
    end
    for (int n = 0; n < 16; n++) begin
      r = $random(seed);
      rail_i <= pga_rail_t'({r[19:8], r[7:4] & r[3:0], 4'h0});
      thermal_warning_status_i <= r[30] ^ r[5];
      {fhold, twsel, od, pol, win, sel} = r[31:20];
      wr(PGA_OFS_CTRL1, {22'h0, od, pol, win, sel});
      wr(PGA_OFS_CTRL2, {29'h0, fhold, 1'b1, twsel});
      wr(PGA_OFS_FAULT, 32'h1f);
      fault_m = 5'h0;
      settle("continuous");
    end
    wr(PGA_OFS_CTRL2, 32'h0, 4'h0);
    rd(PGA_OFS_CTRL2);
    chk("strobe", rdat[2:0], {fhold, 1'b1, twsel});
    wr(PGA_OFS_CTRL1, 32'h0);
    wr(PGA_OFS_CTRL2, 32'h2);
    {sel, win, pol, twsel, fhold} = '0;
    for (int k = 0; k < 2; k++) begin
      {thermal_shutdown_i, input_overvoltage_i} <= 2'(1 << k);
      settle("flag set");
      wr(PGA_OFS_INT, 32'h3);
      settle("flag busy");
      {thermal_shutdown_i, input_overvoltage_i} <= 2'h0;
      settle("flag held");
      wr(PGA_OFS_INT, 32'h3);
      fl_m = 2'h0;
      settle("flag clear");
    end
    rd(8'h20);
    chk("unmapped read", {resp, rdat}, {PGA_RESP_SLVERR, 32'h0});
    wr(8'h24, 32'h1f);
    chk("unmapped write", resp, PGA_RESP_SLVERR);
    input_overvoltage_i <= 1'b1;
    settle("pre uvlo");
    input_overvoltage_i <= 1'b0;
    rst_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    {fl_m, fault_m} = '0;
    boot(1'b1);
    settle("uvlo");
    rd(PGA_OFS_CTRL2);
    chk("mode otp", rdat[1], 1'b1);
    results();
  end
endmodule
`default_nettype wire
